// ---- efh_pkg.sv ----
// constants, pin bundles and register map of the elastic fifo host controller
// assumes a 100 MHz clock and a fifo whose pins are wired straight to this block
package efh_pkg;

  localparam int CLK_NS      = 10;
  localparam int WORD_W      = 4;
  localparam int DEPTH       = 16;
  localparam int SYNC_STAGES = 2;
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 32;
  localparam int CNT_W       = 4;

  // pin timing figures in ns
  localparam int PUSH_WIDTH_NS  = 16;
  localparam int POP_WIDTH_NS   = 24;
  localparam int CLEAR_WIDTH_NS = 24;
  localparam int REMOVAL_NS     = 10;
  localparam int SETUP_NS       = 5;
  localparam int HOLD_NS        = 25;
  localparam int PUSH_FLAG_NS   = 42;
  localparam int POP_FLAG_NS    = 42;

  // least times round up, plus synchroniser latency where a flag is watched
  localparam logic [CNT_W-1:0] PUSH_WIDTH_CYC  = CNT_W'((PUSH_WIDTH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] POP_WIDTH_CYC   = CNT_W'((POP_WIDTH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] CLEAR_WIDTH_CYC = CNT_W'((CLEAR_WIDTH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] REMOVAL_CYC     = CNT_W'((REMOVAL_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] SETUP_CYC       = CNT_W'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] HOLD_CYC        = CNT_W'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] PUSH_GUARD_CYC  =
    CNT_W'((PUSH_FLAG_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES + 1);
  localparam logic [CNT_W-1:0] POP_GUARD_CYC   =
    CNT_W'((POP_FLAG_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES + 1);

  // register byte addresses
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_PUSH   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_POP    = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_RXDATA = 8'h10;

  // field positions
  localparam int CTRL_FLOAT_BIT  = 0;
  localparam int CTRL_CLEAR_BIT  = 1;
  localparam int ST_SPACE_BIT    = 0;
  localparam int ST_VALID_BIT    = 1;
  localparam int ST_PUSHBUSY_BIT = 2;
  localparam int ST_POPBUSY_BIT  = 3;
  localparam int ST_RXREADY_BIT  = 4;
  localparam int ST_INIT_BIT     = 5;
  localparam int ST_CLRBUSY_BIT  = 6;

  localparam logic             FLOAT_RST = 1'b0;
  localparam logic [WORD_W-1:0] WORD_RST = 4'h0;

  typedef struct packed {
    logic              push;
    logic              pop_n;
    logic              clear_control;
    logic              out_float;
    logic [WORD_W-1:0] data_in;
  } efh_pins_out_s;

  typedef struct packed {
    logic              has_space;
    logic              output_valid_flag;
    logic [WORD_W-1:0] data_out;
  } efh_pins_in_s;

  localparam int PIN_IN_W = $bits(efh_pins_in_s);

  typedef enum logic [2:0] {
    P_IDLE  = 3'b000,
    P_WAIT  = 3'b001,
    P_SETUP = 3'b010,
    P_HIGH  = 3'b011,
    P_LOW   = 3'b100,
    P_GUARD = 3'b101
  } efh_push_e;

  typedef enum logic [1:0] {
    Q_IDLE  = 2'b00,
    Q_WAIT  = 2'b01,
    Q_LOW   = 2'b10,
    Q_GUARD = 2'b11
  } efh_pop_e;

  typedef enum logic [1:0] {
    C_IDLE   = 2'b00,
    C_PULSE  = 2'b01,
    C_REMOVE = 2'b10
  } efh_clr_e;

endpackage

// ---- efh_sync.sv ----
// two-stage synchroniser for a bundle of pin inputs
// assumes each bit is a level that is sampled independently
module efh_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] stage1;

  // stage1 feeds nothing but the second stage
  always_ff @(posedge clk) begin
    if (srst) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule // efh_sync

// ---- efh_host.sv ----
// host controller driving a 16x4 elastic fifo through its pins
// assumes the fifo pins connect directly and software uses the plain register port
// Notes on behaviour
// - push returns low between words
// - cascade: valid to push, space to pop
// - clear pulse before any transfer
// - wide words: AND flags, shared strobes
//
// Implementation choices: the register offsets and the plain strobed port.
module efh_host
  import efh_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic [ADDR_W-1:0]   addr,
  input  wire logic [DATA_W-1:0]   wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  output logic      [DATA_W-1:0]   rdata,
  input  wire efh_pins_in_s        pins_in,
  output efh_pins_out_s            pins_out
);

  efh_pins_in_s     pin_s;
  logic [PIN_IN_W-1:0] pin_raw;
  logic [PIN_IN_W-1:0] pin_sync;

  efh_push_e        push_st;
  efh_pop_e         pop_st;
  efh_clr_e         clr_st;
  logic [CNT_W-1:0] push_cnt;
  logic [CNT_W-1:0] pop_cnt;
  logic [CNT_W-1:0] clr_cnt;
  logic [CNT_W-1:0] hold_cnt;

  logic              out_float;
  logic              clr_pend;
  logic              init_done;
  logic              pop_pend;
  logic [WORD_W-1:0] tx_word;
  logic [WORD_W-1:0] rx_word;
  logic              rx_ready;

  logic wr_ctrl;
  logic wr_push;
  logic wr_pop;
  logic rd_rx;
  logic strobes_quiet;
  logic clr_start;
  logic rx_take;

  assign pin_raw = pins_in;
  assign pin_s   = efh_pins_in_s'(pin_sync);

  // flags and data arrive from another timing world
  efh_sync #(
    .W (PIN_IN_W)
  ) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    (pin_raw),
    .q    (pin_sync)
  );

  assign wr_ctrl = wr && (addr == REG_CTRL);
  assign wr_push = wr && (addr == REG_PUSH);
  assign wr_pop  = wr && (addr == REG_POP);
  assign rd_rx   = rd && (addr == REG_RXDATA);

  // clear only between strobes so no edge is cut short
  assign strobes_quiet = (push_st == P_IDLE || push_st == P_WAIT)
                      && (pop_st == Q_IDLE || pop_st == Q_WAIT);
  assign clr_start     = (clr_st == C_IDLE) && (clr_pend || !init_done) && strobes_quiet;
  // a clear starting this cycle must not overlap a pop pulse
  assign rx_take       = (pop_st == Q_WAIT) && (clr_st == C_IDLE) && !clr_start
                      && pin_s.output_valid_flag;

  always_ff @(posedge clk) begin
    if (srst) begin
      out_float <= FLOAT_RST;
    end else if (wr_ctrl) begin
      out_float <= wdata[CTRL_FLOAT_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      clr_pend <= 1'b0;
    end else if (wr_ctrl && wdata[CTRL_CLEAR_BIT]) begin
      clr_pend <= 1'b1;
    end else if (clr_start) begin
      clr_pend <= 1'b0;
    end
  end

  // clear pulse, issued on its own after reset before any transfer and again on each clear request
  always_ff @(posedge clk) begin
    if (srst) begin
      clr_st    <= C_IDLE;
      clr_cnt   <= '0;
      init_done <= 1'b0;
    end else begin
      case (clr_st)
        C_IDLE: begin
          if (clr_start) begin
            clr_st  <= C_PULSE;
            clr_cnt <= CLEAR_WIDTH_CYC;
          end
        end
        C_PULSE: begin
          if (clr_cnt == CNT_W'(1)) begin
            clr_st  <= C_REMOVE;
            clr_cnt <= REMOVAL_CYC;
          end else begin
            clr_cnt <= clr_cnt - CNT_W'(1);
          end
        end
        C_REMOVE: begin
          if (clr_cnt == CNT_W'(1)) begin
            clr_st    <= C_IDLE;
            init_done <= 1'b1;
          end else begin
            clr_cnt <= clr_cnt - CNT_W'(1);
          end
        end
        default: clr_st <= C_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_word <= WORD_RST;
    end else if (wr_push && push_st == P_IDLE) begin
      tx_word <= wdata[WORD_W-1:0];
    end
  end

  // push sequence: wait for space, set up data, raise, lower, let flags settle
  always_ff @(posedge clk) begin
    if (srst) begin
      push_st  <= P_IDLE;
      push_cnt <= '0;
      hold_cnt <= '0;
    end else begin
      case (push_st)
        P_IDLE: begin
          if (wr_push) begin
            push_st <= P_WAIT;
          end
        end
        P_WAIT: begin
          // push stays low through clear so it cannot load a stray word
          if (pin_s.has_space && init_done && clr_st == C_IDLE && !clr_start) begin
            push_st  <= P_SETUP;
            push_cnt <= SETUP_CYC;
          end
        end
        P_SETUP: begin
          if (push_cnt == CNT_W'(1)) begin
            push_st  <= P_HIGH;
            push_cnt <= PUSH_WIDTH_CYC;
          end else begin
            push_cnt <= push_cnt - CNT_W'(1);
          end
        end
        P_HIGH: begin
          if (push_cnt == CNT_W'(1)) begin
            push_st  <= P_LOW;
            push_cnt <= PUSH_WIDTH_CYC;
            hold_cnt <= HOLD_CYC;
          end else begin
            push_cnt <= push_cnt - CNT_W'(1);
          end
        end
        P_LOW: begin
          if (hold_cnt != '0) begin
            hold_cnt <= hold_cnt - CNT_W'(1);
          end
          if (push_cnt == CNT_W'(1) && hold_cnt <= CNT_W'(1)) begin
            push_st  <= P_GUARD;
            push_cnt <= PUSH_GUARD_CYC;
          end else if (push_cnt > CNT_W'(1)) begin
            push_cnt <= push_cnt - CNT_W'(1);
          end
        end
        P_GUARD: begin
          // space dips after each accept; a stale high must not start another word
          if (push_cnt == CNT_W'(1)) begin
            push_st <= P_IDLE;
          end else begin
            push_cnt <= push_cnt - CNT_W'(1);
          end
        end
        default: push_st <= P_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pop_pend <= 1'b0;
    end else if (wr_pop && pop_st == Q_IDLE) begin
      pop_pend <= 1'b1;
    end else if (pop_st == Q_WAIT) begin
      pop_pend <= 1'b0;
    end
  end

  // pop sequence: wait for a word at the outputs, take it, pulse pop low
  always_ff @(posedge clk) begin
    if (srst) begin
      pop_st  <= Q_IDLE;
      pop_cnt <= '0;
    end else begin
      case (pop_st)
        Q_IDLE: begin
          if (pop_pend && init_done) begin
            pop_st <= Q_WAIT;
          end
        end
        Q_WAIT: begin
          if (rx_take) begin
            pop_st  <= Q_LOW;
            pop_cnt <= POP_WIDTH_CYC;
          end
        end
        Q_LOW: begin
          if (pop_cnt == CNT_W'(1)) begin
            pop_st  <= Q_GUARD;
            pop_cnt <= POP_GUARD_CYC;
          end else begin
            pop_cnt <= pop_cnt - CNT_W'(1);
          end
        end
        Q_GUARD: begin
          // valid drops after the pop; wait until that is visible here
          if (pop_cnt == CNT_W'(1)) begin
            pop_st <= Q_IDLE;
          end else begin
            pop_cnt <= pop_cnt - CNT_W'(1);
          end
        end
        default: pop_st <= Q_IDLE;
      endcase
    end
  end

  // data was settled before valid rose, both pass the same synchroniser
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_word <= WORD_RST;
    end else if (rx_take) begin
      rx_word <= pin_s.data_out;
    end
  end

  // a new word wins over a read in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_ready <= 1'b0;
    end else if (rx_take) begin
      rx_ready <= 1'b1;
    end else if (rd_rx) begin
      rx_ready <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        REG_CTRL: rdata <= {31'h0, out_float};
        REG_PUSH: rdata <= {28'h0, tx_word};
        REG_STATUS: begin
          rdata                  <= '0;
          rdata[ST_SPACE_BIT]    <= pin_s.has_space;
          rdata[ST_VALID_BIT]    <= pin_s.output_valid_flag;
          rdata[ST_PUSHBUSY_BIT] <= (push_st != P_IDLE);
          rdata[ST_POPBUSY_BIT]  <= (pop_st != Q_IDLE) || pop_pend;
          rdata[ST_RXREADY_BIT]  <= rx_ready;
          rdata[ST_INIT_BIT]     <= init_done;
          rdata[ST_CLRBUSY_BIT]  <= (clr_st != C_IDLE) || clr_pend;
        end
        REG_RXDATA: rdata <= {28'h0, rx_word};
        default:    rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // pin drive; one word per push edge, the fifo ripples it stage by stage
  always_ff @(posedge clk) begin
    if (srst) begin
      pins_out.push          <= 1'b0;
      pins_out.pop_n         <= 1'b1;
      pins_out.clear_control <= 1'b0;
      pins_out.out_float     <= FLOAT_RST;
      pins_out.data_in       <= WORD_RST;
    end else begin
      pins_out.push          <= (push_st == P_HIGH);
      pins_out.pop_n         <= !(pop_st == Q_LOW);
      pins_out.clear_control <= (clr_st == C_PULSE);
      pins_out.out_float     <= out_float;
      pins_out.data_in       <= tx_word;
    end
  end

endmodule // efh_host

// ---- efh_host_assertions.sv ----
// pin and register port checks for the fifo host controller
// assumes it is bound onto efh_host; one clock, synchronous reset
module efh_host_assertions
  import efh_pkg::*;
(
  input logic              clk,
  input logic              srst,
  input logic [ADDR_W-1:0] addr,
  input logic [DATA_W-1:0] wdata,
  input logic              wr,
  input logic              rd,
  input logic [DATA_W-1:0] rdata,
  input efh_pins_in_s      pins_in,
  input efh_pins_out_s     pins_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence push_pulse;
    pins_out.push [*2] ##1 !pins_out.push [*3];
  endsequence
  sequence pop_pulse;
    !pins_out.pop_n [*3] ##1 pins_out.pop_n;
  endsequence
  // 8 cycles outlasts the flag synchroniser plus setup
  sequence space_gone;
    !pins_in.has_space [*8];
  endsequence
  sequence valid_gone;
    !pins_in.output_valid_flag [*8];
  endsequence
  chk_push_shape: assert property ($rose(pins_out.push) |-> push_pulse)
    else $error("push pulse has wrong shape");
  chk_pop_shape: assert property ($fell(pins_out.pop_n) |-> pop_pulse)
    else $error("pop pulse has wrong shape");
  chk_full_holds: assert property (space_gone |=> !$rose(pins_out.push))
    else $error("push while fifo full");
  chk_empty_holds: assert property (valid_gone |=> !$fell(pins_out.pop_n))
    else $error("pop while fifo empty");
  chk_clear_shape: assert property ($rose(pins_out.clear_control) |->
    pins_out.clear_control [*3] ##1 !pins_out.clear_control)
    else $error("clear pulse has wrong width");
  chk_clear_boot: assert property ($fell(srst) |-> ##[1:4] pins_out.clear_control)
    else $error("no clear after reset");
  chk_clear_quiet: assert property (pins_out.clear_control |->
    !pins_out.push && pins_out.pop_n)
    else $error("strobe active during clear");
  chk_data_held: assert property (pins_out.push |=> $stable(pins_out.data_in))
    else $error("data moved under push");
  chk_float_follow: assert property (wr && addr == REG_CTRL |=> ##1
    pins_out.out_float == $past(wdata[CTRL_FLOAT_BIT], 2))
    else $error("float control not applied");
endmodule // efh_host_assertions
bind efh_host efh_host_assertions efh_host_assertions_i (
  .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .pins_in(pins_in), .pins_out(pins_out));

// ---- efh_fifo_model.sv ----
// behavioural 16x4 marker fifo on the far side of the host pins
// assumes pins change just after clk; stall slows the ripple
module efh_fifo_model
  import efh_pkg::*;
(
  input  logic          clk,
  input  logic          stall,
  input  efh_pins_out_s pins_out,
  output efh_pins_in_s  pins_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DEPTH-1:0]  mark = '0;
  logic [WORD_W-1:0] word [DEPTH];
  logic [DEPTH-1:0]  m;
  logic [WORD_W-1:0] w [DEPTH];
  logic              push_q = 1'b0;
  logic              pop_q = 1'b1;
  logic              took;
  always @(posedge clk) begin
    m = mark;
    w = word;
    took = 1'b0;
    if (pins_out.clear_control) begin
      m = '0;
    end else begin
      if (!pins_out.pop_n && pop_q && m[DEPTH-1]) m[DEPTH-1] = 1'b0;
      for (int i = DEPTH - 1; i > 0; i--) begin
        if (!stall && !m[i] && m[i-1]) begin
          m[i] = 1'b1;
          m[i-1] = 1'b0;
          w[i] = w[i-1];
        end
      end
      // held strobe retries, so a word waits out a full fifo or a clear
      if (pins_out.push && !push_q && !m[0]) begin
        m[0] = 1'b1;
        w[0] = pins_out.data_in;
        took = 1'b1;
      end
    end
    mark <= m;
    word <= w;
    push_q <= pins_out.push && (push_q || took);
    pop_q <= pins_out.pop_n;
  end
  // floated lines show the inverse, never a stale word
  assign pins_in = {!mark[0], mark[DEPTH-1],
    pins_out.out_float ? ~word[DEPTH-1] : word[DEPTH-1]};
endmodule // efh_fifo_model

// ---- testbench.sv ----
// self-checking bench for the fifo host controller and fifo model
// assumes efh_host, efh_fifo_model and the bound checker are compiled
module testbench;
  import efh_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk = 0, srst = 1, wr = 0, rd = 0, stall = 0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata, v;
  efh_pins_in_s      pins_in;
  efh_pins_out_s     pins_out;
  int                seed = 33948, n_fail = 0, n_compared = 0, cyc = 0;
  logic [WORD_W-1:0] q [$];
  efh_host efh_host_i (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pins_in(pins_in), .pins_out(pins_out));
  efh_fifo_model efh_fifo_model_i (.clk(clk), .stall(stall), .pins_out(pins_out),
    .pins_in(pins_in));
  initial forever #5 clk = ~clk;
  task automatic wrap_up;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // cut a hang short well past the expected run length
  always @(posedge clk) begin
    stall <= ($random(seed) & 3) == 0;
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      wrap_up;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic await(input int b, input logic val);
    for (int k = 0; k < 300; k++) begin
      rreg(REG_STATUS, v);
      if (v[b] === val) break;
    end
    chk({31'h0, v[b]}, {31'h0, val});
  endtask
  // expected {valid, space} once n words have settled
  function automatic logic [1:0] flags(input int n);
    return {n > 0, n < DEPTH};
  endfunction
  task automatic push_w(input logic [WORD_W-1:0] w);
    wreg(REG_PUSH, {28'h0, w});
    q.push_back(w);
    await(ST_PUSHBUSY_BIT, 1'b0);
  endtask
  task automatic pop_chk(input logic req);
    if (req) wreg(REG_POP, 32'h0);
    await(ST_RXREADY_BIT, 1'b1);
    rreg(REG_RXDATA, v);
    chk(v[3:0], q.pop_front());
    await(ST_POPBUSY_BIT, 1'b0);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    await(ST_INIT_BIT, 1'b1);
    chk(v[1:0], flags(0));
    wreg(REG_POP, 32'h0);
    repeat (40) @(posedge clk);
    chk(pins_out.pop_n, 1'b1);
    push_w(4'hA);
    pop_chk(1'b0);
    repeat (DEPTH) push_w(4'($random(seed)));
    repeat (30) @(posedge clk);
    rreg(REG_STATUS, v);
    chk(v[1:0], flags(DEPTH));
    wreg(REG_PUSH, 32'h5);
    q.push_back(4'h5);
    repeat (40) @(posedge clk);
    chk(pins_out.push, 1'b0);
    repeat (DEPTH + 1) pop_chk(1'b1);
    rreg(REG_STATUS, v);
    chk(v[1:0], flags(0));
    repeat (3) push_w(4'($random(seed)));
    repeat (30) @(posedge clk);
    wreg(REG_CTRL, 32'h2);
    await(ST_CLRBUSY_BIT, 1'b0);
    repeat (4) @(posedge clk);
    rreg(REG_STATUS, v);
    chk(v[1:0], flags(0));
    q.delete();
    push_w(4'h9);
    rreg(REG_PUSH, v);
    chk(v, 32'h9);
    pop_chk(1'b1);
    wreg(REG_CTRL, 32'h1);
    rreg(REG_CTRL, v);
    chk(v[1:0], 2'b01);
    push_w(4'h3);
    wreg(REG_POP, 32'h0);
    await(ST_RXREADY_BIT, 1'b1);
    await(ST_POPBUSY_BIT, 1'b0);
    rreg(REG_STATUS, v);
    chk(v[1:0], flags(0));
    rreg(REG_RXDATA, v);
    wreg(REG_CTRL, 32'h0);
    rreg(8'h40, v);
    chk(v, 32'h0);
    wrap_up;
  end
endmodule // testbench
